// [inc/pdm_params.svh]
`ifndef PDM_PARAMS_SVH
`define PDM_PARAMS_SVH
// byte offsets on the register bus
`define PDM_OFS_NOMINAL 8'h00
`define PDM_OFS_CMD 8'h04
`define PDM_OFS_CFG 4'h0
`define PDM_OFS_LIMIT 4'h4
`define PDM_OFS_DEMAND 4'h8
`define PDM_OFS_STATUS 4'hc
// command bits
`define PDM_CMD_CLEAR 0
// reset values
`define PDM_NOMINAL_RST 24'h002710
`define PDM_LIMIT_RST 16'h0064
`define PDM_RESP_RST 3'h2
`define PDM_INTERVAL_RST 3'h3
// time base
`define PDM_SEC_PER_MIN 11'h03c
`define PDM_SEC_LAST 6'h3b
`define PDM_T0_MIN 6'h05
`define PDM_T1_MIN 6'h0a
`define PDM_T2_MIN 6'h0f
`define PDM_T3_MIN 6'h14
`define PDM_T4_MIN 6'h1e
// per-second weight 1-exp(-2.3/(60*T)) scaled by 2^16
`define PDM_ALPHA_FRAC 16
`define PDM_T0_ALPHA 10'h1f4
`define PDM_T1_ALPHA 10'h0fb
`define PDM_T2_ALPHA 10'h0a7
`define PDM_T3_ALPHA 10'h07d
`define PDM_T4_ALPHA 10'h054
// auto-ranging thresholds in kVA and unit steps in kW
`define PDM_KVA_1MVA 24'h0003e8
`define PDM_KVA_10MVA 24'h002710
`define PDM_STEP_FINE 16'h000a
`define PDM_STEP_COARSE 16'h0064
`define PDM_VA_LIMIT_MIN 32'h00000001
`define PDM_VA_LIMIT_MAX 32'h00007530
`endif

// [inc/pdm_pkg.sv]
package pdm_pkg;
  typedef enum logic [1:0] {act_off, act_alarm, act_latch} pdm_action_e;
  typedef enum logic [1:0] {meth_thermal, meth_block, meth_rolling}
    pdm_method_e;
  typedef struct packed {
    logic [4:0] relays;
    logic [2:0] interval;
    logic [2:0] resp;
    pdm_method_e method;
    pdm_action_e action;
  } pdm_cfg_s;
  typedef struct packed {
    logic valid;
    logic [10:0] minute;
    logic [5:0] sec;
    logic [2:0][23:0] val;
  } pdm_meas_s;
  typedef struct packed {
    logic signed [39:0] therm;
    logic signed [39:0] acc;
    logic [10:0] cnt;
    logic signed [39:0] macc;
    logic signed [39:0] mdone;
    logic signed [39:0] roll;
    logic [4:0] ptr;
    logic [5:0] filled;
    logic [1:0] pend;
    logic signed [31:0] demand;
  } pdm_chan_s;
  typedef struct packed {
    pdm_chan_s [2:0] ch;
    pdm_cfg_s [2:0] cfg;
    logic [2:0][15:0] limit;
    logic [23:0] nominal;
    logic [2:0] restart;
    logic [4:0] relay;
    logic clr;
    logic ack;
    logic [31:0] rdata;
  } pdm_top_s;
  typedef struct packed {
    logic alarm;
    logic pickup;
  } pdm_alarm_s;
endpackage

// [logic/pdm_ram.sv]
`timescale 1ns/1ns
module pdm_ram #(
  parameter int W = 40,
  parameter int D = 32,
  parameter int A = 5
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // write side
  input wire logic wr_en,
  input wire logic [A-1:0] wr_addr,
  input wire logic [W-1:0] wr_data,
  // read side, data one cycle after the address
  input wire logic [A-1:0] rd_addr,
  output logic [W-1:0] rd_data
);
  logic [W-1:0] mem [D];

  always_ff @(posedge clock) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rd_data <= '0;
    end else begin
      rd_data <= mem[rd_addr];
    end
  end
endmodule

// [logic/pdm_alarm.sv]
`timescale 1ns/1ns
module pdm_alarm
  import pdm_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // comparison inputs
  input wire logic signed [31:0] demand,
  input wire logic signed [31:0] limit_kw,
  input wire pdm_action_e action,
  input wire logic clr,
  // result
  output logic alarm,
  output logic pickup
);
  pdm_alarm_s st;
  pdm_alarm_s nx;

  always_comb begin
    nx = st;
    nx.pickup = (action != act_off) && (demand >= limit_kw);
    case (action)
      act_alarm: nx.alarm = nx.pickup;
      // a clear during pickup loses: the alarm stays set
      act_latch: nx.alarm = nx.pickup | (st.alarm & ~clr);
      default: nx.alarm = 1'b0;
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= nx;
    end
  end

  assign alarm = st.alarm;
  assign pickup = st.pickup;
endmodule

// [logic/pdm_top.sv]
// Operation
// - Real power demand at or above its limit raises alarm and relays.
// - Reactive power demand at or above its limit raises alarm and relays.
// - Apparent power demand at or above its limit raises alarm and relays.
// - The response setting sets the time to reach 90% in thermal mode.
// - Limits scale as kilo units below 1 MVA, 0.01 or 0.1 mega above.
// - Each element is disabled, alarm or latched alarm; off means silent.
// - Thermal, block or rolling averaging forms the compared demand.
// - Response and interval pick 5, 10, 15, 20 or 30 min; 15 and 20 reset.
// - Any subset of auxiliary relays 3 to 7 operates on pickup.
// - Apparent limit spans 1 to 30000 kVA, default 10.0 MVA.
// - Thermal mode steps once per sample toward the input by 1-exp(-k/60).
// - Block mode averages intervals aligned to midnight, updated at end.
// - Rolling mode recomputes the average over the last interval each min.
`timescale 1ns/1ns
`include "pdm_params.svh"
module pdm_top
  import pdm_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // avalon-mm slave
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  // once-per-second power samples and time of day
  input wire pdm_meas_s meas,
  // element outputs: 0 real, 1 reactive, 2 apparent
  output logic [2:0] demand_alarm,
  output logic [4:0] aux_relay
);
  pdm_top_s st;
  pdm_top_s nx;
  logic [2:0] alarm_w;
  logic [2:0] pick_w;
  logic [2:0] ram_we;
  logic [2:0][4:0] ram_ra;
  logic [2:0][39:0] ram_rd;
  logic [2:0][31:0] limit_kw;

  //////////////////////////////////////////////////////////////////////////
  function automatic logic [5:0] pdm_minutes(input logic [2:0] code);
    case (code)
      3'h0: return `PDM_T0_MIN;
      3'h1: return `PDM_T1_MIN;
      3'h2: return `PDM_T2_MIN;
      3'h3: return `PDM_T3_MIN;
      default: return `PDM_T4_MIN;
    endcase
  endfunction

  function automatic logic [9:0] pdm_alpha(input logic [2:0] code);
    case (code)
      3'h0: return `PDM_T0_ALPHA;
      3'h1: return `PDM_T1_ALPHA;
      3'h2: return `PDM_T2_ALPHA;
      3'h3: return `PDM_T3_ALPHA;
      default: return `PDM_T4_ALPHA;
    endcase
  endfunction

  // limit in the auto-ranged unit, returned in kW, kvar or kVA
  function automatic logic [31:0] pdm_scale(input logic [15:0] lim,
                                            input logic [23:0] nom);
    if (nom < `PDM_KVA_1MVA) begin
      return {16'h0000, lim};
    end else if (nom < `PDM_KVA_10MVA) begin
      return lim * `PDM_STEP_FINE;
    end else begin
      return lim * `PDM_STEP_COARSE;
    end
  endfunction

  function automatic logic [31:0] pdm_merge(input logic [31:0] old,
                                            input logic [31:0] wd,
                                            input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[b*8 +: 8] = wd[b*8 +: 8];
      end
    end
    return r;
  endfunction

  //////////////////////////////////////////////////////////////////////////
  always_comb begin
    limit_kw[0] = pdm_scale(st.limit[0], st.nominal);
    limit_kw[1] = pdm_scale(st.limit[1], st.nominal);
    limit_kw[2] = pdm_scale(st.limit[2], st.nominal);
    // the apparent limit never leaves its documented span
    if (limit_kw[2] < `PDM_VA_LIMIT_MIN) begin
      limit_kw[2] = `PDM_VA_LIMIT_MIN;
    end else if (limit_kw[2] > `PDM_VA_LIMIT_MAX) begin
      limit_kw[2] = `PDM_VA_LIMIT_MAX;
    end
  end

  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : gen_ch
      assign ram_we[g] = st.ch[g].pend[1];
      assign ram_ra[g] = st.ch[g].ptr
                         - 5'(pdm_minutes(st.cfg[g].interval));
      pdm_ram #(.W(40), .D(32), .A(5)) pdm_ram_inst (
        .clock(clock),
        .rst_n(rst_n),
        .wr_en(ram_we[g]),
        .wr_addr(st.ch[g].ptr),
        .wr_data(st.ch[g].mdone),
        .rd_addr(ram_ra[g]),
        .rd_data(ram_rd[g])
      );
      pdm_alarm pdm_alarm_inst (
        .clock(clock),
        .rst_n(rst_n),
        .demand(st.ch[g].demand),
        .limit_kw(limit_kw[g]),
        .action(st.cfg[g].action),
        .clr(st.clr),
        .alarm(alarm_w[g]),
        .pickup(pick_w[g])
      );
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////
  always_comb begin
    logic signed [41:0] diff;
    logic signed [52:0] prod;
    logic signed [39:0] x;
    logic signed [39:0] sum;
    logic signed [39:0] old;
    logic [5:0] nmin;
    logic [5:0] mins;
    logic [10:0] m1;
    logic [10:0] cnt1;
    logic [31:0] mw;
    logic blk_end;
    diff = '0;
    prod = '0;
    x = '0;
    sum = '0;
    old = '0;
    nmin = '0;
    mins = '0;
    m1 = '0;
    cnt1 = '0;
    mw = '0;
    blk_end = 1'b0;
    nx = st;
    nx.clr = 1'b0;
    nx.restart = 3'h0;
    // one wait state on every access, then the answer
    nx.ack = (read | write) & ~st.ack;

    // register writes take effect at the accepting edge
    if (st.ack && write) begin
      if (address == `PDM_OFS_NOMINAL) begin
        mw = pdm_merge({8'h00, st.nominal}, writedata, byteenable);
        nx.nominal = mw[23:0];
      end else if (address == `PDM_OFS_CMD) begin
        nx.clr = byteenable[0] & writedata[`PDM_CMD_CLEAR];
      end
      for (int c = 0; c < 3; c++) begin
        if (address[7:4] == 4'(c + 1)) begin
          case (address[3:0])
            `PDM_OFS_CFG: begin
              mw = pdm_merge({17'h00000, st.cfg[c]}, writedata,
                             byteenable);
              nx.cfg[c] = pdm_cfg_s'(mw[14:0]);
              if (nx.cfg[c].method != st.cfg[c].method ||
                  nx.cfg[c].interval != st.cfg[c].interval) begin
                nx.restart[c] = 1'b1;
              end
            end
            `PDM_OFS_LIMIT: begin
              mw = pdm_merge({16'h0000, st.limit[c]}, writedata,
                             byteenable);
              nx.limit[c] = mw[15:0];
            end
            default: ;
          endcase
        end
      end
    end

    // read data is loaded as the request is first seen
    if (nx.ack && read) begin
      nx.rdata = 32'h0;
      if (address == `PDM_OFS_NOMINAL) begin
        nx.rdata = {8'h00, st.nominal};
      end else if (address == `PDM_OFS_CMD) begin
        nx.rdata = {24'h000000, st.relay, alarm_w};
      end
      for (int c = 0; c < 3; c++) begin
        if (address[7:4] == 4'(c + 1)) begin
          case (address[3:0])
            `PDM_OFS_CFG: nx.rdata = {17'h00000, st.cfg[c]};
            `PDM_OFS_LIMIT: nx.rdata = {16'h0000, st.limit[c]};
            `PDM_OFS_DEMAND: nx.rdata = st.ch[c].demand;
            `PDM_OFS_STATUS: nx.rdata = {30'h0, pick_w[c], alarm_w[c]};
            default: nx.rdata = 32'h0;
          endcase
        end
      end
    end

    // relays follow the registered alarms
    nx.relay = 5'h00;
    for (int c = 0; c < 3; c++) begin
      if (alarm_w[c]) begin
        nx.relay = nx.relay | st.cfg[c].relays;
      end
    end

    // demand engines, one per quantity
    for (int c = 0; c < 3; c++) begin
      nmin = pdm_minutes(st.cfg[c].interval);
      x = 40'(signed'(meas.val[c]));
      if (st.restart[c]) begin
        nx.ch[c] = '0;
      end else begin
        nx.ch[c].pend = {st.ch[c].pend[0], 1'b0};
        if (meas.valid) begin
          // thermal: held sample, first-order step per second
          diff = 42'(x <<< `PDM_ALPHA_FRAC) - 42'(st.ch[c].therm);
          prod = 53'(diff) * 53'(signed'({1'b0,
                                  pdm_alpha(st.cfg[c].resp)}));
          nx.ch[c].therm = st.ch[c].therm
                           + 40'(prod >>> `PDM_ALPHA_FRAC);
          if (st.cfg[c].method == meth_thermal) begin
            nx.ch[c].demand = 32'(nx.ch[c].therm >>> `PDM_ALPHA_FRAC);
          end
          // block: midnight-aligned, result only at the boundary
          m1 = meas.minute + 11'h001;
          blk_end = (meas.sec == `PDM_SEC_LAST) &&
                    ((m1 % {5'h00, nmin}) == 11'h000);
          sum = st.ch[c].acc + x;
          cnt1 = st.ch[c].cnt + 11'h001;
          if (blk_end) begin
            nx.ch[c].acc = '0;
            nx.ch[c].cnt = '0;
            if (st.cfg[c].method == meth_block) begin
              nx.ch[c].demand = 32'(sum / signed'({29'h0, cnt1}));
            end
          end else begin
            nx.ch[c].acc = sum;
            nx.ch[c].cnt = cnt1;
          end
          // one-minute partial sums feed the rolling window
          if (meas.sec == `PDM_SEC_LAST) begin
            nx.ch[c].mdone = st.ch[c].macc + x;
            nx.ch[c].macc = '0;
            nx.ch[c].pend[0] = 1'b1;
          end else begin
            nx.ch[c].macc = st.ch[c].macc + x;
          end
        end
        // rolling: ram holds the minute that leaves the window
        if (st.ch[c].pend[1]) begin
          old = (st.ch[c].filled >= nmin) ? signed'(ram_rd[c]) : '0;
          sum = st.ch[c].roll + st.ch[c].mdone - old;
          mins = (st.ch[c].filled >= nmin) ? nmin
                 : st.ch[c].filled + 6'h01;
          nx.ch[c].roll = sum;
          nx.ch[c].filled = mins;
          nx.ch[c].ptr = st.ch[c].ptr + 5'h01;
          if (st.cfg[c].method == meth_rolling) begin
            nx.ch[c].demand = 32'(sum / signed'({29'h0,
                              11'(mins * `PDM_SEC_PER_MIN)}));
          end
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
      st.nominal <= `PDM_NOMINAL_RST;
      st.limit <= {3{`PDM_LIMIT_RST}};
      st.cfg <= {3{5'h00, `PDM_INTERVAL_RST, `PDM_RESP_RST,
                 meth_thermal, act_off}};
    end else begin
      st <= nx;
    end
  end

  assign readdata = st.rdata;
  assign waitrequest = ~st.ack;
  assign demand_alarm = alarm_w;
  assign aux_relay = st.relay;
endmodule

// [sim/pdm_meas_model.sv]
`timescale 1ns/1ns
module pdm_meas_model
  import pdm_pkg::*;
(
  // clock
  input wire logic clock,
  // samples towards the monitor
  output pdm_meas_s meas
);
  initial begin
    meas = '0;
  end
  ////////////////////////////////////////////////////////////////////////
  // lines show the inverse after the strobe, never a stale copy
  task automatic send(input logic [10:0] m, input logic [5:0] s,
                      input logic [23:0] p, q, va);
    meas <= {1'b1, m, s, va, q, p};
    @(posedge clock);
    meas <= {1'b0, ~m, ~s, ~va, ~q, ~p};
    repeat (4) @(posedge clock);
  endtask
endmodule

// [sim/pdm_top_sva.sv]
`timescale 1ns/1ns
module pdm_top_sva
  import pdm_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // bus
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  // samples and outputs
  input wire pdm_meas_s meas,
  input wire logic [2:0] demand_alarm,
  input wire logic [4:0] aux_relay
);
  // outputs may only move a few cycles after a sample or a write
  logic [3:0] hist;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      hist <= 4'h0;
    end else begin
      hist <= {hist[2:0], meas.valid | write};
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////////////
  AST_ONE_WAIT: assert property (!waitrequest |=> waitrequest)
    else $error("answer held longer than one cycle");
  AST_ANSWER: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("request not answered after one wait cycle");
  AST_IDLE: assert property (!(read || write) |=> waitrequest)
    else $error("answer without a request");
  AST_RD_HOLD: assert property (!read |=> $stable(readdata))
    else $error("read data moved without a read");
  AST_RST_QUIET: assert property ($rose(rst_n) |-> waitrequest &&
    demand_alarm == 3'h0 && aux_relay == 5'h0)
    else $error("outputs active right after reset");
  AST_STATUS_RD: assert property (read && !waitrequest &&
    address == 8'h04 && $stable(demand_alarm) && $stable(aux_relay)
    |-> readdata == {24'h0, aux_relay, demand_alarm})
    else $error("status read disagrees with outputs");
  AST_ALARM_CAUSE: assert property ($changed(demand_alarm) |->
    hist != 4'h0)
    else $error("alarm moved with no sample or write");
  AST_RELAY_CAUSE: assert property ($changed(aux_relay) |->
    $past(demand_alarm) != $past(demand_alarm, 2) || hist != 4'h0)
    else $error("relays moved with no cause");
  AST_RELAY_NEEDS_ALARM: assert property (aux_relay != 5'h0 |->
    $past(demand_alarm) != 3'h0)
    else $error("relay on with no alarm");
endmodule
bind pdm_top pdm_top_sva pdm_top_sva_inst (.clock(clock), .rst_n(rst_n),
  .address(address), .read(read), .write(write), .readdata(readdata),
  .waitrequest(waitrequest), .meas(meas), .demand_alarm(demand_alarm),
  .aux_relay(aux_relay));

// [sim/power_demand_monitor_tb.sv]
`timescale 1ns/1ns
module power_demand_monitor_tb
  import pdm_pkg::*;
;
  logic clock, rst_n, read, write, waitrequest;
  logic [7:0] address;
  logic [3:0] byteenable;
  logic [31:0] writedata, readdata, rd_v;
  logic [2:0] demand_alarm;
  logic [4:0] aux_relay;
  pdm_meas_s meas;
  int n_fail, checks, cyc, i;
  pdm_top pdm_top_inst (.clock(clock), .rst_n(rst_n), .address(address),
    .read(read), .write(write), .byteenable(byteenable),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .meas(meas), .demand_alarm(demand_alarm), .aux_relay(aux_relay));
  pdm_meas_model pdm_meas_model_inst (.clock(clock), .meas(meas));
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    $display("checks %0d failures %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // the whole run needs about 1900 cycles
  always @(posedge clock) begin
    cyc = cyc + 1;
    if (cyc == 6000) begin
      n_fail++;
      $display("Error %0t: timeout", $time);
      stop_test();
    end
  end
  task automatic chk(input logic [31:0] got, exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic chkr(input logic [31:0] got, input int lo, hi);
    checks++;
    if ($isunknown(got) || $signed(got) < lo || $signed(got) > hi) begin
      n_fail++;
      $display("Error %0t: %0d out of range", $time, $signed(got));
    end
  endtask
  // outputs packed as relays over alarms
  task automatic chko(input logic [31:0] exp);
    chk({24'h0, aux_relay, demand_alarm}, exp);
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    address <= a;
    writedata <= d;
    write <= 1'b1;
    do @(posedge clock); while (waitrequest !== 1'b0);
    write <= 1'b0;
    @(posedge clock);
  endtask
  // plain read, the value is left in rd_v for the caller to judge
  task automatic rdv(input logic [7:0] a);
    address <= a;
    read <= 1'b1;
    do @(posedge clock); while (waitrequest !== 1'b0);
    rd_v = readdata;
    read <= 1'b0;
    @(posedge clock);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    rdv(a);
    chk(rd_v, exp);
  endtask
  task automatic snd(input logic [10:0] m, input logic [5:0] s,
                     input logic [23:0] p, q, va);
    pdm_meas_model_inst.send(m, s, p, q, va);
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic t_defaults();
    rd(8'h30, 32'h1a0);
    rd(8'h34, 32'h64);
    rd(8'h00, 32'h2710);
    rd(8'hfc, 32'h0);
    chko(32'h0);
    $display("test defaults done");
  endtask
  task automatic t_real();
    wr(8'h00, 32'h1f4);
    wr(8'h14, 32'h64);
    wr(8'h10, 32'h1401);
    for (i = 0; i < 10; i++) begin
      snd(11'h0, 6'h0, 24'h3e8, 24'h0, 24'h0);
    end
    chko(32'h0);
    for (i = 10; i < 300; i++) begin
      snd(11'h0, 6'h0, 24'h3e8, 24'h0, 24'h0);
    end
    rdv(8'h18);
    chkr(rd_v, 880, 910);
    chko(32'h29);
    rd(8'h1c, 32'h3);
    rd(8'h04, 32'h29);
    wr(8'h14, 32'h7d0);
    repeat (3) @(posedge clock);
    chko(32'h0);
    $display("test real done");
  endtask
  task automatic t_var();
    wr(8'h00, 32'h1388);
    wr(8'h24, 32'h5);
    wr(8'h20, 32'h6006);
    snd(11'h4, 6'h3a, 24'h0, 24'h50, 24'h0);
    rd(8'h28, 32'h0);
    snd(11'h4, 6'h3b, 24'h0, 24'h50, 24'h0);
    rd(8'h28, 32'h50);
    chko(32'hc2);
    snd(11'h9, 6'h3b, 24'h0, 24'h0, 24'h0);
    rd(8'h28, 32'h0);
    rd(8'h2c, 32'h1);
    wr(8'h04, 32'h1);
    repeat (3) @(posedge clock);
    chko(32'h0);
    $display("test var done");
  endtask
  task automatic t_va();
    wr(8'h00, 32'h4e20);
    wr(8'h34, 32'h2);
    wr(8'h30, 32'h809);
    for (i = 0; i < 60; i++) begin
      snd(11'h0, 6'(i), 24'h0, 24'h0, 24'h96);
    end
    rd(8'h38, 32'h96);
    chko(32'h0);
    wr(8'h34, 32'h1);
    repeat (3) @(posedge clock);
    chko(32'h14);
    wr(8'h30, 32'h808);
    repeat (3) @(posedge clock);
    chko(32'h0);
    wr(8'h30, 32'h805);
    rd(8'h38, 32'h0);
    $display("test va done");
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    rst_n = 1'b0;
    read = 1'b0;
    write = 1'b0;
    address = 8'h00;
    byteenable = 4'hf;
    writedata = 32'h0;
    n_fail = 0;
    checks = 0;
    cyc = 0;
    repeat (4) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    t_defaults();
    t_real();
    t_var();
    t_va();
    stop_test();
  end
endmodule
